// File: txsi_clk_monitor.sv
// Loss-of-transmit-clock detector on the reference clock.
// Assumes the transmit clock pin is asynchronous to the reference clock.
`timescale 1ns/1ps
module txsi_clk_monitor
  import txsi_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic tx_clk_pin,
  txsi_evt_if.clkmon evt
);
  logic meta_ff;
  logic sync_ff;
  logic prev_ff;
  logic [7:0] idle_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      meta_ff <= tx_clk_pin;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  // Any edge restarts the idle count; the count saturates at the limit
  always_ff @(posedge clk) begin
    if (rst) begin
      idle_ff <= 8'h00;
    end else if (sync_ff != prev_ff) begin
      idle_ff <= 8'h00;
    end else if (idle_ff != 8'(LOSS_CYC)) begin
      idle_ff <= idle_ff + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      evt.clk_lost <= 1'b0;
    end else begin
      evt.clk_lost <= (idle_ff == 8'(LOSS_CYC)) && (sync_ff == prev_ff);
    end
  end
endmodule : txsi_clk_monitor

// File: txsi_core.sv
// Transmit status, mask and synchronizer control registers of one port.
// Assumes event inputs are one-cycle pulses from logic on REF_CLK.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
// Behaviour
// - Sync-on bit 2 of the synchronizer control switches the synchronizer.
// - Bit 1 set suppresses automatic resynchronization.
// - Bit 0 rising from 0 to 1 starts one resync.
// - Store-full latches at status 1 bit 7 when a frame is dropped.
// - Store-empty latches at bit 6 when a frame is repeated.
// - Slip latches at bit 5 on either full or empty slip.
// - T1 with enable: bit 4 latches once per 72 frames.
// - Bit 2 latches on each multiframe boundary, mode dependent.
// - Bit 1 latches when the transmit clock returns.
// - Bit 0 latches after about three idle clock periods.
// - Clock-loss pin follows the fault itself when enabled.
// - Unmasked set flags pull the interrupt output low while control bit 1 is set.
// - T1: status 2 bit 4 latches when data-link register empties.
// - FIFO empty without message end latches bit 3, sends abort.
// - Bit 2 latches when a message has been sent.
// - Bit 1 latches on rising edge of below-watermark.
// - Bit 0 latches on rising edge of FIFO not full.
// - Status 3 bit 1 shows hunting in real time.
// - Status 3 bit 0 latches when hunting starts.
// - Summary bits 0..2 show unmasked pending per status group.
// - Mask bits match flag positions; 1 enables the interrupt.
// - Watermark select codes give 4, 16, 32 or 48 bytes.
module txsi_core
  import txsi_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic [8:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic TX_CLOCK_INPUT,
  input wire logic FRAME_PULSE,
  input wire logic E1_MODE,
  input wire logic ESF_MODE,
  input wire logic SF72_ENABLE,
  input wire logic STORE_FULL_IN,
  input wire logic STORE_EMPTY_IN,
  input wire logic DATALINK_SHIFTED,
  input wire logic FIFO_RAN_EMPTY,
  input wire logic MSG_END_MARKED,
  input wire logic MSG_SENT,
  input wire logic [6:0] FIFO_LEVEL,
  input wire logic SYNC_HUNT,
  output logic SYNC_ON,
  output logic AUTO_RESYNC_INHIBIT,
  output logic RESYNC_START,
  output logic SEND_ABORT,
  output logic CLOCK_LOSS_PIN,
  output logic IRQ_OUT_N
);
  txsi_evt_if evt ();

  txsi_frame_timer u_timer (
    .clk(REF_CLK),
    .rst(RESET),
    .frame_pulse(FRAME_PULSE),
    .e1_mode(E1_MODE),
    .esf_mode(ESF_MODE),
    .evt(evt.timer)
  );

  txsi_clk_monitor u_clkmon (
    .clk(REF_CLK),
    .rst(RESET),
    .tx_clk_pin(TX_CLOCK_INPUT),
    .evt(evt.clkmon)
  );

  logic [7:0] sync_ctl_ff;
  logic [7:0] wm_sel_ff;
  logic [7:0] ctl_ff;
  logic [7:0] ls1_ff;
  logic [7:0] ls2_ff;
  logic [7:0] ls3_ff;
  logic [7:0] im1_ff;
  logic [7:0] im2_ff;
  logic [7:0] im3_ff;
  logic [7:0] nxt_ls1;
  logic [7:0] nxt_ls2;
  logic [7:0] nxt_ls3;
  logic [7:0] set1;
  logic [7:0] set2;
  logic [7:0] set3;
  logic [7:0] rd_mux;
  logic [2:0] pending;
  logic lost_prev_ff;
  logic below_prev_ff;
  logic notfull_prev_ff;
  logic hunt_prev_ff;
  logic below_now;
  logic not_full_now;
  logic underrun;

  function automatic logic wr_hit(input logic [8:0] a);
    wr_hit = WR && (ADDR == a);
  endfunction : wr_hit

  // Hardware sets win over a same-cycle software clear
  function automatic logic [7:0] w1c(input logic [7:0] cur, input logic [7:0] set,
                                      input logic hit);
    w1c = (hit ? (cur & ~WDATA) : cur) | set;
  endfunction : w1c

  // Control registers
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      sync_ctl_ff <= REG_RESET;
    end else if (wr_hit(ADDR_SYNC)) begin
      sync_ctl_ff <= WDATA & SYNC_MASK;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      wm_sel_ff <= REG_RESET;
    end else if (wr_hit(ADDR_WM)) begin
      wm_sel_ff <= WDATA & LOW2_MASK;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      ctl_ff <= REG_RESET;
    end else if (wr_hit(ADDR_CTL)) begin
      ctl_ff <= WDATA & LOW2_MASK;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      im1_ff <= REG_RESET;
      im2_ff <= REG_RESET;
      im3_ff <= REG_RESET;
    end else begin
      if (wr_hit(ADDR_IM1)) begin
        im1_ff <= WDATA;
      end
      if (wr_hit(ADDR_IM2)) begin
        im2_ff <= WDATA & LS2_MASK;
      end
      if (wr_hit(ADDR_IM3)) begin
        im3_ff <= WDATA & LS3_MASK;
      end
    end
  end

  assign SYNC_ON = sync_ctl_ff[SYNC_ON_BIT];
  assign AUTO_RESYNC_INHIBIT = sync_ctl_ff[INHIBIT_BIT];

  // Only a written 0 -> 1 change counts; rewriting 1 does nothing
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      RESYNC_START <= 1'b0;
    end else begin
      RESYNC_START <= wr_hit(ADDR_SYNC) && WDATA[RESYNC_BIT]
                      && !sync_ctl_ff[RESYNC_BIT];
    end
  end

  // Edge history of the real-time conditions
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      lost_prev_ff <= 1'b0;
      // An idle FIFO is empty: no false below or not-full edge after reset
      below_prev_ff <= 1'b1;
      notfull_prev_ff <= 1'b1;
      hunt_prev_ff <= 1'b0;
    end else begin
      lost_prev_ff <= evt.clk_lost;
      below_prev_ff <= below_now;
      notfull_prev_ff <= not_full_now;
      hunt_prev_ff <= SYNC_HUNT;
    end
  end

  assign below_now = FIFO_LEVEL < wm_level(wm_sel_ff[1:0]);
  assign not_full_now = FIFO_LEVEL < FIFO_DEPTH;
  assign underrun = FIFO_RAN_EMPTY && !MSG_END_MARKED;

  always_comb begin
    set1 = 8'h00;
    set1[FULL_BIT] = STORE_FULL_IN;
    set1[EMPTY_BIT] = STORE_EMPTY_IN;
    set1[SLIP_BIT] = STORE_FULL_IN || STORE_EMPTY_IN;
    set1[SF72_BIT] = evt.sf72_tick && SF72_ENABLE && !E1_MODE;
    set1[ALIGN_BIT] = evt.align_tick && E1_MODE;
    set1[MF_BIT] = evt.mf_tick;
    set1[RESTORED_BIT] = lost_prev_ff && !evt.clk_lost;
    set1[LOSS_BIT] = evt.clk_lost && !lost_prev_ff;
  end

  always_comb begin
    set2 = 8'h00;
    set2[DLE_BIT] = DATALINK_SHIFTED && !E1_MODE;
    set2[UDR_BIT] = underrun;
    set2[MEND_BIT] = MSG_SENT;
    set2[LWM_BIT] = below_now && !below_prev_ff;
    set2[NF_BIT] = not_full_now && !notfull_prev_ff;
  end

  always_comb begin
    set3 = 8'h00;
    set3[HUNT_EV_BIT] = SYNC_HUNT && !hunt_prev_ff;
  end

  assign nxt_ls1 = w1c(ls1_ff, set1, wr_hit(ADDR_LS1));
  assign nxt_ls2 = w1c(ls2_ff, set2, wr_hit(ADDR_LS2));
  assign nxt_ls3 = w1c(ls3_ff, set3, wr_hit(ADDR_LS3));

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      ls1_ff <= REG_RESET;
      ls2_ff <= REG_RESET;
      ls3_ff <= REG_RESET;
    end else begin
      ls1_ff <= nxt_ls1;
      ls2_ff <= nxt_ls2 & LS2_MASK;
      ls3_ff <= nxt_ls3 & LS3_MASK;
    end
  end

  // Abort is issued in the same cycle the underrun flag is latched
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      SEND_ABORT <= 1'b0;
    end else begin
      SEND_ABORT <= underrun;
    end
  end

  // Pin tracks the fault, not the flag, so a host clear does not drop it
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      CLOCK_LOSS_PIN <= 1'b0;
    end else begin
      CLOCK_LOSS_PIN <= evt.clk_lost && ctl_ff[PIN_EN_BIT];
    end
  end

  assign pending[0] = |(ls1_ff & im1_ff);
  assign pending[1] = |(ls2_ff & im2_ff);
  assign pending[2] = |(ls3_ff & im3_ff);
  assign IRQ_OUT_N = !(ctl_ff[IRQ_EN_BIT] && |pending);

  always_comb begin
    rd_mux = 8'h00;
    unique case (ADDR)
      ADDR_WM: rd_mux = wm_sel_ff;
      ADDR_SYNC: rd_mux = sync_ctl_ff;
      ADDR_LS1: rd_mux = ls1_ff;
      ADDR_LS2: rd_mux = ls2_ff;
      ADDR_LS3: begin
        rd_mux = ls3_ff;
        rd_mux[HUNT_NOW_BIT] = SYNC_HUNT;
      end
      ADDR_SUM: rd_mux = {5'h00, pending};
      ADDR_IM1: rd_mux = im1_ff;
      ADDR_IM2: rd_mux = im2_ff;
      ADDR_IM3: rd_mux = im3_ff;
      ADDR_CTL: rd_mux = ctl_ff;
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      RDATA <= 8'h00;
    end else begin
      RDATA <= RD ? rd_mux : 8'h00;
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  a_resync_edge_pulse: assert property (
    wr_hit(ADDR_SYNC) && WDATA[RESYNC_BIT] && !sync_ctl_ff[RESYNC_BIT]
    |=> RESYNC_START ##1 !RESYNC_START)
    else $error("resync pulse missing or too long");

  a_resync_no_repeat: assert property (
    sync_ctl_ff[RESYNC_BIT] && wr_hit(ADDR_SYNC) |=> !RESYNC_START)
    else $error("resync started without a 0 to 1 change");

  a_slip_both_cases: assert property (
    STORE_FULL_IN || STORE_EMPTY_IN |=> ls1_ff[SLIP_BIT])
    else $error("slip flag not latched");

  a_loss_pin_fault: assert property (
    evt.clk_lost && ctl_ff[PIN_EN_BIT] && !wr_hit(ADDR_CTL)
    |=> CLOCK_LOSS_PIN)
    else $error("loss pin low during fault");

  a_irq_from_flag: assert property (
    ls1_ff[LOSS_BIT] && im1_ff[LOSS_BIT] && ctl_ff[IRQ_EN_BIT] |-> !IRQ_OUT_N)
    else $error("interrupt not asserted for clock loss");

  a_irq_released: assert property (
    $fell(|pending) && ctl_ff[IRQ_EN_BIT] |-> IRQ_OUT_N)
    else $error("interrupt held with nothing pending");

  a_underrun_abort: assert property (
    FIFO_RAN_EMPTY && !MSG_END_MARKED |=> SEND_ABORT && ls2_ff[UDR_BIT])
    else $error("underrun without abort");

  a_watermark_edge: assert property (
    $rose(below_now) && !wr_hit(ADDR_LS2) ##1 1'b1 |-> ls2_ff[LWM_BIT])
    else $error("watermark edge not latched");

  a_w1c_clear: assert property (
    wr_hit(ADDR_LS1) && WDATA[MF_BIT] && !set1[MF_BIT] |=> !ls1_ff[MF_BIT])
    else $error("write one did not clear flag");

  a_summary_read: assert property (
    RD && ADDR == ADDR_SUM |=> RDATA == {5'h00, $past(pending)})
    else $error("summary read mismatch");

  a_full_latch: assert property (
    STORE_FULL_IN |=> ls1_ff[FULL_BIT])
    else $error("store full flag not latched");

  a_mf_latch: assert property (
    evt.mf_tick |=> ls1_ff[MF_BIT])
    else $error("multiframe flag not latched");

  a_restored_set: assert property (
    $fell(evt.clk_lost) |=> ls1_ff[RESTORED_BIT])
    else $error("clock restored flag not latched");

  a_loss_flag_set: assert property (
    $rose(evt.clk_lost) |=> ls1_ff[LOSS_BIT])
    else $error("clock loss flag not latched");

  a_not_full_edge: assert property (
    not_full_now && !notfull_prev_ff |=> ls2_ff[NF_BIT])
    else $error("not full edge not latched");

  a_hunt_live: assert property (
    RD && ADDR == ADDR_LS3 |=> RDATA[HUNT_NOW_BIT] == $past(SYNC_HUNT))
    else $error("live hunt bit mismatch");

  a_hunt_event: assert property (
    SYNC_HUNT && !hunt_prev_ff |=> ls3_ff[HUNT_EV_BIT])
    else $error("hunt event not latched");
endmodule : txsi_core

// File: txsi_evt_if.sv
// Timing and clock-monitor indications passed to the status core.
// Assumes all producers run on the same reference clock.
`timescale 1ns/1ps
interface txsi_evt_if;
  logic sf72_tick;
  logic align_tick;
  logic mf_tick;
  logic clk_lost;
  modport timer (output sf72_tick, output align_tick, output mf_tick);
  modport clkmon (output clk_lost);
  modport core (input sf72_tick, input align_tick, input mf_tick, input clk_lost);
endinterface : txsi_evt_if

// File: txsi_frame_timer.sv
// Frame counter giving superframe, align-frame and multiframe ticks.
// Assumes one frame pulse per 125 us frame, on the reference clock.
`timescale 1ns/1ps
module txsi_frame_timer
  import txsi_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic frame_pulse,
  input wire logic e1_mode,
  input wire logic esf_mode,
  txsi_evt_if.timer evt
);
  logic [6:0] cnt_ff;
  logic [6:0] wrap;
  logic [6:0] nxt_cnt;

  // 72 covers both T1 multiframe lengths, 16 covers the E1 one
  assign wrap = e1_mode ? FR_E1MF : FR_SF72;
  // A T1 count above the E1 wrap after a mode change folds back at once
  assign nxt_cnt = (cnt_ff >= wrap - 7'h01) ? 7'h00 : cnt_ff + 7'h01;

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff <= 7'h00;
    end else if (frame_pulse) begin
      cnt_ff <= nxt_cnt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      evt.sf72_tick <= 1'b0;
      evt.align_tick <= 1'b0;
      evt.mf_tick <= 1'b0;
    end else begin
      evt.sf72_tick <= frame_pulse && !e1_mode && (nxt_cnt == 7'h00);
      evt.align_tick <= frame_pulse && e1_mode && (nxt_cnt % FR_ALIGN == 7'h00);
      if (e1_mode) begin
        evt.mf_tick <= frame_pulse && (nxt_cnt == 7'h00);
      end else begin
        evt.mf_tick <= frame_pulse && (nxt_cnt % (esf_mode ? FR_ESF : FR_D4) == 7'h00);
      end
    end
  end
endmodule : txsi_frame_timer

// File: txsi_pkg.sv
// Constants shared by the transmit status and interrupt block.
// Assumes a 9-bit byte address and 8-bit registers on a plain port.
package txsi_pkg;
  localparam logic [8:0] ADDR_WM = 9'h187;
  localparam logic [8:0] ADDR_SYNC = 9'h18e;
  localparam logic [8:0] ADDR_LS1 = 9'h190;
  localparam logic [8:0] ADDR_LS2 = 9'h191;
  localparam logic [8:0] ADDR_LS3 = 9'h192;
  localparam logic [8:0] ADDR_SUM = 9'h19f;
  localparam logic [8:0] ADDR_IM1 = 9'h1a0;
  localparam logic [8:0] ADDR_IM2 = 9'h1a1;
  localparam logic [8:0] ADDR_IM3 = 9'h1a2;
  localparam logic [8:0] ADDR_CTL = 9'h1a3;
  localparam int SYNC_ON_BIT = 2;
  localparam int INHIBIT_BIT = 1;
  localparam int RESYNC_BIT = 0;
  localparam int FULL_BIT = 7;
  localparam int EMPTY_BIT = 6;
  localparam int SLIP_BIT = 5;
  localparam int SF72_BIT = 4;
  localparam int ALIGN_BIT = 3;
  localparam int MF_BIT = 2;
  localparam int RESTORED_BIT = 1;
  localparam int LOSS_BIT = 0;
  localparam int DLE_BIT = 4;
  localparam int UDR_BIT = 3;
  localparam int MEND_BIT = 2;
  localparam int LWM_BIT = 1;
  localparam int NF_BIT = 0;
  localparam int HUNT_NOW_BIT = 1;
  localparam int HUNT_EV_BIT = 0;
  localparam int PIN_EN_BIT = 0;
  localparam int IRQ_EN_BIT = 1;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] LS2_MASK = 8'h1f;
  localparam logic [7:0] LS3_MASK = 8'h01;
  localparam logic [7:0] SYNC_MASK = 8'h07;
  localparam logic [7:0] LOW2_MASK = 8'h03;
  localparam logic [6:0] FR_D4 = 7'h0c;
  localparam logic [6:0] FR_ESF = 7'h18;
  localparam logic [6:0] FR_E1MF = 7'h10;
  localparam logic [6:0] FR_SF72 = 7'h48;
  localparam logic [6:0] FR_ALIGN = 7'h02;
  localparam logic [6:0] FIFO_DEPTH = 7'h40;
  localparam int TXCLK_PERIOD_NS = 648;
  localparam int LOSS_PERIODS = 3;
  localparam int REF_PERIOD_NS = 20;
  localparam int LOSS_CYC = (LOSS_PERIODS * TXCLK_PERIOD_NS) / REF_PERIOD_NS;

  function automatic logic [6:0] wm_level(input logic [1:0] sel);
    unique case (sel)
      2'h0: wm_level = 7'h04;
      2'h1: wm_level = 7'h10;
      2'h2: wm_level = 7'h20;
      2'h3: wm_level = 7'h30;
    endcase
  endfunction : wm_level
endpackage : txsi_pkg

// File: txsi_tb.sv
// Self-checking bench for the transmit status and interrupt core.
// Assumes txsi_pkg is compiled first; the bench drives every port itself.
`timescale 1ns/1ps
module testbench;
  import txsi_pkg::*;
  logic REF_CLK = 0;
  logic RESET = 1;
  logic [8:0] ADDR = 0;
  logic [7:0] WDATA = 0;
  logic WR = 0;
  logic RD = 0;
  logic [7:0] RDATA;
  logic TX_CLOCK_INPUT = 0;
  logic tx_run = 1;
  logic [5:0] ev = 0;
  logic E1_MODE = 0;
  logic ESF_MODE = 0;
  logic SF72_ENABLE = 0;
  logic MSG_END_MARKED = 0;
  logic SYNC_HUNT = 0;
  logic [6:0] FIFO_LEVEL = 7'h40;
  logic SYNC_ON, AUTO_RESYNC_INHIBIT, RESYNC_START, SEND_ABORT, CLOCK_LOSS_PIN, IRQ_OUT_N;
  int error_cnt = 0;
  int checks = 0;
  int rs_cnt = 0;
  int ab_cnt = 0;
  int n;
  logic [7:0] expq[$];
  logic rd_q = 0;
  logic [7:0] r;
  logic [6:0] thr[4] = '{7'h04, 7'h10, 7'h20, 7'h30};
  logic [8:0] rst_addr[7] = '{ADDR_LS1, ADDR_LS2, ADDR_LS3, ADDR_SUM, ADDR_IM1, ADDR_IM2, 9'h1ff};

  txsi_core DUT (.REF_CLK(REF_CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .TX_CLOCK_INPUT(TX_CLOCK_INPUT), .FRAME_PULSE(ev[5]),
    .E1_MODE(E1_MODE), .ESF_MODE(ESF_MODE), .SF72_ENABLE(SF72_ENABLE),
    .STORE_FULL_IN(ev[0]), .STORE_EMPTY_IN(ev[1]), .DATALINK_SHIFTED(ev[2]),
    .FIFO_RAN_EMPTY(ev[3]), .MSG_END_MARKED(MSG_END_MARKED), .MSG_SENT(ev[4]),
    .FIFO_LEVEL(FIFO_LEVEL), .SYNC_HUNT(SYNC_HUNT), .SYNC_ON(SYNC_ON),
    .AUTO_RESYNC_INHIBIT(AUTO_RESYNC_INHIBIT), .RESYNC_START(RESYNC_START),
    .SEND_ABORT(SEND_ABORT), .CLOCK_LOSS_PIN(CLOCK_LOSS_PIN), .IRQ_OUT_N(IRQ_OUT_N));

  always #10 REF_CLK = ~REF_CLK;
  // Half period never lands on a rising reference edge, so the pin is truly unrelated
  always #324 if (tx_run) TX_CLOCK_INPUT = ~TX_CLOCK_INPUT;

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
      error_cnt++;
    end
  endtask : chk

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run

  // Read data stand only in the cycle after the strobe
  always @(posedge REF_CLK) begin
    if (rd_q) chk("read data", RDATA, expq.pop_front());
    rd_q <= RD;
    rs_cnt <= rs_cnt + int'(RESYNC_START);
    ab_cnt <= ab_cnt + int'(SEND_ABORT);
  end

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    WR <= 1;
    ADDR <= a;
    WDATA <= d;
    @(posedge REF_CLK);
    WR <= 0;
    @(posedge REF_CLK);
  endtask : wr

  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    expq.push_back(e);
    RD <= 1;
    ADDR <= a;
    @(posedge REF_CLK);
    RD <= 0;
    @(posedge REF_CLK);
  endtask : rd

  task automatic pulse(input int k);
    ev[k] <= 1;
    @(posedge REF_CLK);
    ev[k] <= 0;
    @(posedge REF_CLK);
  endtask : pulse

  initial begin
    #1000000;
    error_cnt++;
    complete_run();
  end

  initial begin
    void'($urandom(32'h7e5982b2));
    repeat (8) @(posedge REF_CLK);
    RESET <= 0;
    @(posedge REF_CLK);
    foreach (rst_addr[i]) rd(rst_addr[i], REG_RESET);
    r = 8'($urandom);
    wr(ADDR_IM1, r);
    rd(ADDR_IM1, r);
    wr(ADDR_IM2, r);
    rd(ADDR_IM2, r & LS2_MASK);
    wr(9'h1ff, r);
    rd(9'h1ff, 8'h00);
    $display("test registers done");

    wr(ADDR_SYNC, 8'h06);
    chk("sync on", {7'h0, SYNC_ON}, 8'h01);
    chk("inhibit", {7'h0, AUTO_RESYNC_INHIBIT}, 8'h01);
    wr(ADDR_SYNC, 8'h07);
    rd(ADDR_SYNC, 8'h07);
    chk("resync count", 8'(rs_cnt), 8'h01);
    wr(ADDR_SYNC, 8'h07);
    rd(ADDR_SYNC, 8'h07);
    chk("resync count", 8'(rs_cnt), 8'h01);
    wr(ADDR_SYNC, 8'h00);
    chk("sync on", {7'h0, SYNC_ON}, 8'h00);
    chk("inhibit", {7'h0, AUTO_RESYNC_INHIBIT}, 8'h00);
    wr(ADDR_SYNC, 8'h01);
    rd(ADDR_SYNC, 8'h01);
    chk("resync count", 8'(rs_cnt), 8'h02);
    $display("test synchronizer done");

    wr(ADDR_IM1, 8'h80);
    wr(ADDR_IM2, 8'h00);
    wr(ADDR_CTL, 8'h02);
    wr(ADDR_LS1, 8'hff);
    pulse(0);
    rd(ADDR_LS1, 8'ha0);
    chk("irq", {7'h0, IRQ_OUT_N}, 8'h00);
    rd(ADDR_SUM, 8'h01);
    pulse(1);
    rd(ADDR_LS1, 8'he0);
    wr(ADDR_LS1, 8'h80);
    rd(ADDR_LS1, 8'h60);
    chk("irq", {7'h0, IRQ_OUT_N}, 8'h01);
    rd(ADDR_SUM, 8'h00);
    wr(ADDR_LS1, 8'hff);
    $display("test store events done");

    wr(ADDR_LS2, 8'hff);
    pulse(2);
    rd(ADDR_LS2, 8'h10);
    pulse(3);
    rd(ADDR_LS2, 8'h18);
    chk("abort count", 8'(ab_cnt), 8'h01);
    MSG_END_MARKED <= 1;
    pulse(3);
    rd(ADDR_LS2, 8'h18);
    chk("abort count", 8'(ab_cnt), 8'h01);
    MSG_END_MARKED <= 0;
    pulse(4);
    rd(ADDR_LS2, 8'h1c);
    wr(ADDR_IM2, 8'h04);
    rd(ADDR_SUM, 8'h02);
    chk("irq", {7'h0, IRQ_OUT_N}, 8'h00);
    wr(ADDR_LS2, 8'hff);
    rd(ADDR_SUM, 8'h00);
    $display("test packet events done");

    for (int i = 0; i < 4; i++) begin
      wr(ADDR_WM, 8'(i));
      FIFO_LEVEL <= FIFO_DEPTH;
      repeat (2) @(posedge REF_CLK);
      wr(ADDR_LS2, 8'hff);
      FIFO_LEVEL <= thr[i];
      repeat (2) @(posedge REF_CLK);
      rd(ADDR_LS2, 8'h01);
      FIFO_LEVEL <= thr[i] - 7'h01;
      repeat (2) @(posedge REF_CLK);
      rd(ADDR_LS2, 8'h03);
    end
    $display("test watermark done");

    SYNC_HUNT <= 1;
    repeat (2) @(posedge REF_CLK);
    rd(ADDR_LS3, 8'h03);
    wr(ADDR_LS3, 8'hff);
    rd(ADDR_LS3, 8'h02);
    SYNC_HUNT <= 0;
    wr(ADDR_SUM, 8'hff);
    rd(ADDR_LS3, 8'h00);
    rd(ADDR_SUM, 8'h00);
    $display("test hunt done");

    wr(ADDR_LS1, 8'hff);
    repeat (11) pulse(5);
    rd(ADDR_LS1, 8'h00);
    pulse(5);
    repeat (2) @(posedge REF_CLK);
    rd(ADDR_LS1, 8'h04);
    $display("test multiframe done");

    ESF_MODE <= 1;
    SF72_ENABLE <= 1;
    wr(ADDR_LS1, 8'hff);
    repeat (11) pulse(5);
    rd(ADDR_LS1, 8'h00);
    pulse(5);
    rd(ADDR_LS1, 8'h04);
    wr(ADDR_LS1, 8'hff);
    repeat (48) pulse(5);
    rd(ADDR_LS1, 8'h14);
    E1_MODE <= 1;
    ESF_MODE <= 0;
    wr(ADDR_LS1, 8'hff);
    repeat (2) pulse(5);
    rd(ADDR_LS1, 8'h08);
    wr(ADDR_LS1, 8'hff);
    repeat (14) pulse(5);
    rd(ADDR_LS1, 8'h0c);
    wr(ADDR_LS2, 8'hff);
    pulse(2);
    rd(ADDR_LS2, 8'h00);
    E1_MODE <= 0;
    SF72_ENABLE <= 0;
    $display("test frame modes done");

    wr(ADDR_CTL, 8'h03);
    wr(ADDR_IM1, 8'h01);
    wr(ADDR_LS1, 8'hff);
    tx_run = 0;
    n = 0;
    while (CLOCK_LOSS_PIN !== 1'b1 && n < 300) begin
      @(posedge REF_CLK);
      n++;
    end
    if (n == 300) error_cnt++;
    chk("loss delay ok", {7'h0, n > LOSS_CYC - 20 && n < LOSS_CYC + 12}, 8'h01);
    rd(ADDR_LS1, 8'h01);
    chk("irq", {7'h0, IRQ_OUT_N}, 8'h00);
    wr(ADDR_LS1, 8'h01);
    rd(ADDR_LS1, 8'h00);
    chk("irq", {7'h0, IRQ_OUT_N}, 8'h01);
    chk("loss pin", {7'h0, CLOCK_LOSS_PIN}, 8'h01);
    tx_run = 1;
    repeat (100) @(posedge REF_CLK);
    chk("loss pin", {7'h0, CLOCK_LOSS_PIN}, 8'h00);
    rd(ADDR_LS1, 8'h02);
    $display("test clock loss done");
    repeat (2) @(posedge REF_CLK);
    complete_run();
  end
endmodule : testbench
